/* File: hdl/pdcs_pkg.sv */
// Package for the device control and status register pair
// How it works
// [R1] Bits 0..3 are read/write error reporting enables, reset zero.
// [R2] Relaxed ordering enable at bit 4 always reads zero.
// [R3] Bits 7:5 hold the payload limit, read/write, reset 000b.
// [R4] A payload limit above the supported capability stores the capability instead.
// [R5] Supported capability defaults to 001b (256 bytes), loadable from outside.
// [R6] Extended tag bit 8 and phantom bit 9 read zero, no effect.
// [R7] Bit 10 is a sticky auxiliary power enable, reset zero.
// [R8] No-snoop enable at bit 11 always reads zero.
// [R9] Read request size bits 14:12 are hardwired to 000b.
// [R10] Status bit 16 sets on correctable error, write one clears.
// [R11] Status bit 17 sets on non-fatal error, write one clears.
// [R12] Status bit 18 sets on fatal error, write one clears.
// [R13] Status bit 19 sets on unsupported request, write one clears.
// [R14] Errors are logged regardless of the reporting enables.
// [R15] Status bit 20 reads auxiliary power detected, resets to one.
// [R16] Transactions pending bit 21 is hardwired to zero.
// [R17] Bit 15 and bits 31:22 read zero, writes ignored.
package pdcs_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] DEV_CTRL_STAT_OFFSET = 8'he8;
	localparam logic [7:0] IRQ_STATUS_OFFSET    = 8'hf0;
	localparam logic [7:0] IRQ_CLEAR_OFFSET     = 8'hf4;
	localparam logic [7:0] IRQ_ENABLE_OFFSET    = 8'hf8;
	localparam logic [7:0] PAYLOAD_CAP_OFFSET   = 8'hfc;

	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int ERR_EN_LSB      = 0;
	localparam int PAYLOAD_LSB     = 5;
	localparam int AUX_PWR_EN_BIT  = 10;
	localparam int ERR_DET_LSB     = 16;
	localparam int AUX_DET_BIT     = 20;
	localparam logic [3:0] ERR_EN_RESET   = 4'h0;
	localparam logic [2:0] PAYLOAD_RESET  = 3'h0;
	localparam logic [2:0] PAYLOAD_CAP_RESET = 3'h1;
	localparam logic       AUX_DET_RESET  = 1'b1;

	// Error event group: correctable, non-fatal, fatal, unsupported
	typedef struct packed {
		logic unsupported;
		logic fatal;
		logic nonFatal;
		logic correctable;
	} pdcs_err_type;

endpackage

/* File: hdl/pdcs_regs.sv */
// Device control and status register pair with APB access
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module pdcs_regs (
	input  wire logic                 clk_sys,
	input  wire logic                 reset_n,
	input  wire logic                 stickyReset_n,
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	input  wire logic [3:0]           pstrb,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	input  wire pdcs_pkg::pdcs_err_type errDetect,
	input  wire logic                 auxPowerPresent,
	input  wire logic                 capLoad,
	input  wire logic [2:0]           capLoadValue,
	output pdcs_pkg::pdcs_err_type    errReportEn,
	output logic [2:0]                payloadLimit,
	output logic                      auxPowerEn,
	output logic                      irq
);
	import pdcs_pkg::*;

	// ------------------------------------------------------------
	// Local sizes
	// ------------------------------------------------------------
	localparam int ERR_W     = 4;
	localparam int PAYLOAD_W = 3;

	// ------------------------------------------------------------
	// Storage and next values
	// ------------------------------------------------------------
	pdcs_err_type         errEn_reg;
	pdcs_err_type         errEn_next;
	logic [PAYLOAD_W-1:0] payload_reg;
	logic [PAYLOAD_W-1:0] payload_next;
	logic [PAYLOAD_W-1:0] payloadCap_reg;
	logic [PAYLOAD_W-1:0] payloadCap_next;
	logic                 auxEn_reg;
	logic                 auxEn_next;
	pdcs_err_type         errDet_reg;
	pdcs_err_type         errDet_next;
	pdcs_err_type         irqEn_reg;
	pdcs_err_type         irqEn_next;
	logic                 auxDet_reg;
	logic                 auxDet_next;
	logic                 accDone_reg;
	logic                 accDone_next;
	logic [31:0]          rdData_next;
	logic [31:0]          prdata_next;
	logic                 pslverr_next;
	logic                 irq_next;
	pdcs_err_type         errClr;

	// ------------------------------------------------------------
	// Bus qualifiers
	// ------------------------------------------------------------
	logic accessPhase;
	logic firstAccess;
	logic wrEn;
	logic ctrlHit;
	logic clearHit;
	logic enableHit;
	logic capHit;
	logic mappedHit;
	logic ctrlLowWr;
	logic ctrlAuxWr;
	logic statusClrWr;
	logic irqClrWr;
	logic irqEnWr;
	logic capWr;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Capability is taken at write time; lowering it later leaves the field alone
	function automatic logic [PAYLOAD_W-1:0] clampPayload(
		input logic [PAYLOAD_W-1:0] req,
		input logic [PAYLOAD_W-1:0] cap
	);
		clampPayload = (req > cap) ? cap : req;
	endfunction

	function automatic logic addrMatch(
		input logic [7:0] addr,
		input logic [7:0] offset
	);
		addrMatch = (addr == offset);
	endfunction

	function automatic logic isMapped(
		input logic [7:0] addr
	);
		isMapped = addrMatch(addr, DEV_CTRL_STAT_OFFSET) ||
			addrMatch(addr, IRQ_STATUS_OFFSET) ||
			addrMatch(addr, IRQ_CLEAR_OFFSET) ||
			addrMatch(addr, IRQ_ENABLE_OFFSET) ||
			addrMatch(addr, PAYLOAD_CAP_OFFSET);
	endfunction

	// Only implemented fields are placed; every other bit stays zero
	function automatic logic [31:0] packCtrlStat(
		input pdcs_err_type         en,
		input logic [PAYLOAD_W-1:0] limit,
		input logic                 auxEn,
		input pdcs_err_type         det,
		input logic                 auxDet
	);
		logic [31:0] word;
		word                             = '0;
		word[ERR_EN_LSB +: ERR_W]        = en;
		word[PAYLOAD_LSB +: PAYLOAD_W]   = limit;
		word[AUX_PWR_EN_BIT]             = auxEn;
		word[ERR_DET_LSB +: ERR_W]       = det;
		word[AUX_DET_BIT]                = auxDet;
		packCtrlStat                     = word;
	endfunction

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	assign accessPhase = psel && penable;

	// One wait state: first access edge launches pready, second commits
	assign firstAccess = accessPhase && !accDone_reg;
	assign wrEn        = accessPhase && pwrite && accDone_reg;

	assign ctrlHit   = addrMatch(paddr, DEV_CTRL_STAT_OFFSET);
	assign clearHit  = addrMatch(paddr, IRQ_CLEAR_OFFSET);
	assign enableHit = addrMatch(paddr, IRQ_ENABLE_OFFSET);
	assign capHit    = addrMatch(paddr, PAYLOAD_CAP_OFFSET);
	assign mappedHit = isMapped(paddr);

	// [R17] Lanes not listed here write nothing
	assign ctrlLowWr   = wrEn && ctrlHit && pstrb[0];
	assign ctrlAuxWr   = wrEn && ctrlHit && pstrb[1];
	assign statusClrWr = wrEn && ctrlHit && pstrb[2];
	assign irqClrWr    = wrEn && clearHit && pstrb[0];
	assign irqEnWr     = wrEn && enableHit && pstrb[0];
	assign capWr       = wrEn && capHit && pstrb[0];

	assign accDone_next = firstAccess;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			accDone_reg <= 1'b0;
		end else begin
			accDone_reg <= accDone_next;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pready <= 1'b0;
		end else begin
			pready <= firstAccess;
		end
	end

	// ------------------------------------------------------------
	// Control half
	// ------------------------------------------------------------
	// [R1] Reporting enables
	always_comb begin
		errEn_next = errEn_reg;
		if (ctrlLowWr)
			errEn_next = pdcs_err_type'(pwdata[ERR_EN_LSB +: ERR_W]);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			errEn_reg <= pdcs_err_type'(ERR_EN_RESET);
		end else begin
			errEn_reg <= errEn_next;
		end
	end

	// [R3] [R4] Clamped payload limit
	always_comb begin
		payload_next = payload_reg;
		if (ctrlLowWr)
			payload_next = clampPayload(pwdata[PAYLOAD_LSB +: PAYLOAD_W], payloadCap_reg);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			payload_reg <= PAYLOAD_RESET;
		end else begin
			payload_reg <= payload_next;
		end
	end

	// [R5] Preload wins over a bus write in the same cycle
	always_comb begin
		payloadCap_next = payloadCap_reg;
		if (capLoad)
			payloadCap_next = capLoadValue;
		else if (capWr)
			payloadCap_next = pwdata[PAYLOAD_W-1:0];
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			payloadCap_reg <= PAYLOAD_CAP_RESET;
		end else begin
			payloadCap_reg <= payloadCap_next;
		end
	end

	// [R7] Sticky enable; of the two resets only its own clears it
	always_comb begin
		auxEn_next = auxEn_reg;
		if (ctrlAuxWr)
			auxEn_next = pwdata[AUX_PWR_EN_BIT];
	end

	// Separate reset so the enable survives an ordinary device reset
	always_ff @(posedge clk_sys or negedge stickyReset_n) begin
		if (!stickyReset_n) begin
			auxEn_reg <= 1'b0;
		end else begin
			auxEn_reg <= auxEn_next;
		end
	end

	// [R6] [R8] [R9] Bits 8, 9, 11 and 14:12 have no storage

	// ------------------------------------------------------------
	// Status half
	// ------------------------------------------------------------
	// Either clear path may hit the same flag; both are simply merged
	always_comb begin
		errClr = '0;
		if (statusClrWr)
			errClr = pdcs_err_type'(pwdata[ERR_DET_LSB +: ERR_W]);
		if (irqClrWr)
			errClr = errClr | pdcs_err_type'(pwdata[ERR_W-1:0]);
	end

	// [R10] [R11] [R12] [R13] [R14] Set beats clear, enables ignored
	always_comb begin
		errDet_next = (errDet_reg & ~errClr) | errDetect;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			errDet_reg <= '0;
		end else begin
			errDet_reg <= errDet_next;
		end
	end

	// [R15] Presence shown one cycle late, one from reset
	always_comb begin
		auxDet_next = auxPowerPresent;
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			auxDet_reg <= AUX_DET_RESET;
		end else begin
			auxDet_reg <= auxDet_next;
		end
	end

	// [R16] No pending flag is stored; bit 21 stays zero

	// ------------------------------------------------------------
	// Interrupt enable
	// ------------------------------------------------------------
	always_comb begin
		irqEn_next = irqEn_reg;
		if (irqEnWr)
			irqEn_next = pdcs_err_type'(pwdata[ERR_W-1:0]);
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irqEn_reg <= '0;
		end else begin
			irqEn_reg <= irqEn_next;
		end
	end

	assign irq_next = |(errDet_reg & irqEn_reg);

	// ------------------------------------------------------------
	// Read back
	// ------------------------------------------------------------
	// [R2] [R6] [R8] [R9] [R16] [R17] Hardwired zeros stay zero
	always_comb begin
		rdData_next = '0;
		case (paddr)
			DEV_CTRL_STAT_OFFSET: begin
				rdData_next = packCtrlStat(errEn_reg, payload_reg, auxEn_reg,
					errDet_reg, auxDet_reg);
			end
			IRQ_STATUS_OFFSET: begin
				rdData_next[ERR_W-1:0] = errDet_reg;
			end
			IRQ_ENABLE_OFFSET: begin
				rdData_next[ERR_W-1:0] = irqEn_reg;
			end
			PAYLOAD_CAP_OFFSET: begin
				rdData_next[PAYLOAD_W-1:0] = payloadCap_reg;
			end
			default: begin
				rdData_next = '0;
			end
		endcase
	end

	// Data is launched with pready so it stands in the same cycle
	always_comb begin
		prdata_next = '0;
		if (firstAccess && !pwrite)
			prdata_next = rdData_next;
	end

	// Unmapped offsets answer with an error and read zero
	assign pslverr_next = firstAccess && !mappedHit;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			prdata <= '0;
		end else begin
			prdata <= prdata_next;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pslverr <= 1'b0;
		end else begin
			pslverr <= pslverr_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	// Copies lag the registers by one cycle; users see no combinational path
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			errReportEn <= '0;
		end else begin
			errReportEn <= errEn_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			payloadLimit <= PAYLOAD_RESET;
		end else begin
			payloadLimit <= payload_reg;
		end
	end

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			auxPowerEn <= 1'b0;
		end else begin
			auxPowerEn <= auxEn_reg;
		end
	end

	// Level interrupt, high one cycle after any enabled flag is set, low one cycle after none is
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_next;
		end
	end

	// ------------------------------------------------------------
	// Limitations
	// ------------------------------------------------------------
	// Lane 3 carries no writable field
	// Writes to the status mirror are ignored; use the clear word
	// A capability preload does not reclamp a stored limit
	// Back-to-back transfers are taken; each still needs two access edges
	// Error inputs are sampled every cycle; a held level keeps its flag set
	// Clearing while the error is still present leaves the flag set
	// The sticky reset must be held low at power-up with the device reset

endmodule

/* File: sim/pdcs_regs_props.sv */
// Checker for the control and status register pair
`timescale 1ns/1ns
module pdcs_regs_props (
	input wire logic                   clk_sys,
	input wire logic                   reset_n,
	input wire logic                   psel,
	input wire logic                   penable,
	input wire logic                   pwrite,
	input wire logic [7:0]             paddr,
	input wire logic [31:0]            pwdata,
	input wire logic [3:0]             pstrb,
	input wire logic [31:0]            prdata,
	input wire logic                   pready,
	input wire logic                   pslverr,
	input wire pdcs_pkg::pdcs_err_type errDetect,
	input wire pdcs_pkg::pdcs_err_type errReportEn,
	input wire logic                   irq
);
	import pdcs_pkg::*;
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	wire wr = pready && pwrite;
	a_ro_zero: assert property (pready && !pwrite && paddr == 8'he8
		|-> (prdata & 32'hffe0fb10) == 0) else $error("reserved bits read nonzero");
	a_slv_err: assert property (pready
		|-> pslverr == !(paddr inside {8'he8, 8'hf0, 8'hf4, 8'hf8, 8'hfc})) else $error("bad pslverr");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready longer than one cycle");
	a_ready_time: assert property (psel && penable && !pready |=> pready) else $error("late pready");
	a_idle_quiet: assert property (!(psel && penable) |=> !pready) else $error("pready without access");
	a_en_copy: assert property (wr && paddr == 8'he8 && pstrb[0]
		|-> ##2 errReportEn == $past(pwdata[3:0], 2)) else $error("enables not stored");
	a_irq_cause: assert property ($rose(irq) |-> $past(|errDetect) || $past(|errDetect, 2)
		|| $past(wr) || $past(wr, 2)) else $error("irq rose without cause");
	a_irq_clear: assert property (wr && paddr == 8'hf4 && pwdata[3:0] == 4'hf && pstrb[0]
		&& errDetect == 0 ##1 errDetect == 0 |=> !irq) else $error("irq after full clear");
endmodule
bind pdcs_regs pdcs_regs_props chk_u (.*);

/* File: sim/pdcs_regs_test.sv */
// Self-checking bench for the register pair
`timescale 1ns/1ns
module pdcs_regs_test;
	import pdcs_pkg::*;
	logic         clk_sys = 0, reset_n = 0, stickyReset_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic         auxPowerPresent = 1, capLoad = 0, pready, pslverr, irq, auxPowerEn, se;
	logic [7:0]   paddr = 0;
	logic [31:0]  pwdata = 0, prdata, q, d, seed = 32'h0cfb;
	logic [3:0]   pstrb = 4'hf;
	logic [2:0]   capLoadValue = 0, payloadLimit, cap;
	pdcs_err_type errDetect = 0, errReportEn;
	int           n_mismatch = 0, tests_run = 0;
	pdcs_regs dut_u (.*);
	initial forever #2 clk_sys = ~clk_sys;
	function logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Payload limit clamps to the capability
	function logic [31:0] exp(input logic [31:0] w, input logic [3:0] st, input logic [2:0] c);
		return {11'h0, auxPowerPresent, st, 5'h0, w[10], 2'h0, w[7:5] > c ? c : w[7:5], 1'b0, w[3:0]};
	endfunction
	task tally_and_finish;
		if (n_mismatch == 0 && tests_run > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", s, e, g);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys);
		penable <= 1;
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 9);
		if (pready !== 1'b1) begin
			n_mismatch++;
			tally_and_finish();
		end
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		reset_n <= 1;
		stickyReset_n <= 1;
		@(posedge clk_sys);
		apb(0, 8'he8, 0, q);
		chk("reset", exp(0, 0, 3'h1), q);
		for (int i = 0; i < 24; i++) begin
			d = i ? rnd() : '1;
			cap = i ? d[30:28] : 3'h1;
			capLoadValue <= cap;
			capLoad <= 1;
			@(posedge clk_sys);
			capLoad <= 0;
			apb(1, 8'he8, d, q);
			apb(0, 8'he8, 0, q);
			chk("control", exp(d, 0, cap), q);
			chk("limit", d[7:5] > cap ? cap : d[7:5], payloadLimit);
			chk("aux en", d[10], auxPowerEn);
			chk("report en", d[3:0], errReportEn);
		end
		apb(1, 8'hfc, 32'h2, q);
		apb(0, 8'hfc, 0, q);
		chk("capability", 2, q);
		apb(1, 8'he8, 32'he0, q);
		apb(0, 8'he8, 0, q);
		chk("clamp", exp(32'he0, 0, 2), q);
		apb(1, 8'hf8, 32'hf, q);
		apb(1, 8'he8, 0, q);
		for (int i = 0; i < 4; i++) begin
			errDetect <= 4'(1 << i);
			@(posedge clk_sys);
			errDetect <= 0;
			apb(0, 8'he8, 0, q);
			chk("status", exp(0, 4'(1 << i), 1), q);
			chk("irq", 1, irq);
			apb(1, 8'he8, 32'h10000 << i, q);
			apb(0, 8'hf0, 0, q);
			chk("cleared", 0, q);
		end
		errDetect <= 4'hf;
		@(posedge clk_sys);
		errDetect <= 0;
		apb(1, 8'hf4, 32'hf, q);
		apb(0, 8'he8, 0, q);
		chk("clear", exp(0, 0, 1), q);
		chk("irq low", 0, irq);
		apb(0, 8'h10, 0, q);
		chk("unmapped", 0, q);
		chk("slverr", 1, se);
		apb(1, 8'he8, 32'h400, q);
		reset_n <= 0;
		auxPowerPresent <= 0;
		@(posedge clk_sys);
		reset_n <= 1;
		@(posedge clk_sys);
		apb(0, 8'he8, 0, q);
		chk("sticky", exp(32'h400, 0, 1), q);
		stickyReset_n <= 0;
		@(posedge clk_sys);
		stickyReset_n <= 1;
		apb(0, 8'he8, 0, q);
		chk("sticky reset", exp(0, 0, 1), q);
		tally_and_finish();
	end
endmodule
